// file: shared/page_pkg.sv
// Constants for the special register page stack and core pointer block.
// Assumes an 8-bit direct address space whose upper half holds the
// special registers, driven by the core's instruction sequencer.
`default_nettype none

package page_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned PAGE_COUNT = 256;

   // ----------------------------------------------------------------
   // Direct address map (all registers here decode on every page)
   // ----------------------------------------------------------------
   localparam logic [7:0] SPECIAL_BASE = 8'h80;
   localparam logic [7:0] SPECIAL_TOP = 8'hff;
   localparam logic [7:0] ADDR_STACK_TOP_POINTER = 8'h81;
   localparam logic [7:0] ADDR_POINTER_LOW_BYTE = 8'h82;
   localparam logic [7:0] ADDR_POINTER_HIGH_BYTE = 8'h83;
   localparam logic [7:0] ADDR_PAGE_CONTROL_REG = 8'h84;
   localparam logic [7:0] ADDR_PAGE_STACK_MIDDLE = 8'h85;
   localparam logic [7:0] ADDR_PAGE_STACK_BOTTOM = 8'h86;
   localparam logic [7:0] ADDR_PAGE_SELECT = 8'ha7;

   // ----------------------------------------------------------------
   // Populated pages
   // ----------------------------------------------------------------
   localparam logic [7:0] PAGE_LOW = 8'h00;
   localparam logic [7:0] PAGE_HIGH = 8'h0f;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned AUTO_PAGE_ENABLE_BIT = 0;
   localparam logic [7:0] STACK_TOP_RESET = 8'h07;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] EMPTY_PAGE = 8'h00;
   localparam logic [7:0] STACK_STEP = 8'h01;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Stack activity of one cycle; a push wins over a pop
   typedef enum logic [1:0] {
      STACK_HOLD = 2'b00,
      STACK_PUSH = 2'b01,
      STACK_POP = 2'b11
   } stack_op_e;

endpackage : page_pkg

`default_nettype wire

// file: logic/page_stack_cell.sv
// One byte of state that software may write and hardware may reload.
// Assumes load strobes are from the same clock; hardware load wins.
`default_nettype none

module page_stack_cell #(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_hw_load,
   input wire logic [WIDTH-1:0] i_hw_value,
   input wire logic i_sw_load,
   input wire logic [WIDTH-1:0] i_sw_value,
   output logic [WIDTH-1:0] o_value
);

   logic [WIDTH-1:0] value;
   logic [WIDTH-1:0] next_value;

   // Hardware reload beats a software write in the same cycle, so a
   // push never loses its saved page
   always_comb begin
      next_value = value;
      if (i_hw_load) begin
         next_value = i_hw_value;
      end else if (i_sw_load) begin
         next_value = i_sw_value;
      end
   end

   // Register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end

   assign o_value = value;

endmodule // page_stack_cell

`default_nettype wire

// file: logic/sfr_page_stack_and_pointers.sv
// Special register page selection, three-deep page stack, data pointer
// and stack pointer of the core.
// Assumes the sequencer drives one direct access per cycle at most and
// pulses interrupt entry and return for one cycle each.
`default_nettype none


module sfr_page_stack_and_pointers #(
   parameter int unsigned PAGE_W = page_pkg::DATA_W
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [page_pkg::ADDR_W-1:0] i_dir_addr,
   input wire logic i_dir_wr,
   input wire logic i_dir_rd,
   input wire logic [page_pkg::DATA_W-1:0] i_dir_wdata,
   input wire logic i_int_enter,
   input wire logic [PAGE_W-1:0] i_int_page,
   input wire logic i_int_return,
   input wire logic i_stack_push,
   input wire logic i_stack_pop,
   output logic [page_pkg::DATA_W-1:0] o_dir_rdata,
   output logic o_dir_rd_hit,
   output logic [PAGE_W-1:0] o_page_select,
   output logic o_page_low_active,
   output logic o_page_high_active,
   output logic [15:0] o_indirect_pointer_16,
   output logic [page_pkg::DATA_W-1:0] o_stack_top_pointer
);

   import page_pkg::*;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic wr_select, wr_middle, wr_bottom, wr_control;
   logic in_special, wr_top_ptr, wr_ptr_lo, wr_ptr_hi;

   // Core registers answer on every page, so the page value plays no
   // part here; paged peripherals qualify with the page outputs
   always_comb begin
      in_special = (i_dir_addr >= SPECIAL_BASE) && (i_dir_addr <= SPECIAL_TOP);
      wr_select = i_dir_wr && (i_dir_addr == ADDR_PAGE_SELECT);
      wr_middle = i_dir_wr && (i_dir_addr == ADDR_PAGE_STACK_MIDDLE);
      wr_bottom = i_dir_wr && (i_dir_addr == ADDR_PAGE_STACK_BOTTOM);
      wr_control = i_dir_wr && (i_dir_addr == ADDR_PAGE_CONTROL_REG);
      wr_top_ptr = i_dir_wr && (i_dir_addr == ADDR_STACK_TOP_POINTER);
      wr_ptr_lo = i_dir_wr && (i_dir_addr == ADDR_POINTER_LOW_BYTE);
      wr_ptr_hi = i_dir_wr && (i_dir_addr == ADDR_POINTER_HIGH_BYTE);
   end

   // ----------------------------------------------------------------
   // Page control
   // ----------------------------------------------------------------
   logic auto_page_enable;
   logic next_auto_page_enable;

   // Only the enable bit is stored; the other bits read as zero
   always_comb begin
      next_auto_page_enable = auto_page_enable;
      if (wr_control) begin
         next_auto_page_enable = i_dir_wdata[AUTO_PAGE_ENABLE_BIT];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         auto_page_enable <= 1'b1;
      end else begin
         auto_page_enable <= next_auto_page_enable;
      end
   end

   // ----------------------------------------------------------------
   // Page stack
   // ----------------------------------------------------------------
   stack_op_e stack_op;
   logic [PAGE_W-1:0] page_select, page_stack_middle, page_stack_bottom;
   logic [PAGE_W-1:0] hw_select, hw_middle, sw_page;

   // Entry wins over a return in the same cycle; with paging off the
   // stack ignores both, so the routine keeps whatever page it had
   always_comb begin
      stack_op = STACK_HOLD;
      if (auto_page_enable && i_int_enter) begin
         stack_op = STACK_PUSH;
      end else if (auto_page_enable && i_int_return) begin
         stack_op = STACK_POP;
      end
   end

   // A pop refills the bottom with the empty marker, so a later pop
   // with nothing saved returns page zero
   always_comb begin
      hw_select = page_stack_middle;
      hw_middle = page_stack_bottom;
      if (stack_op == STACK_PUSH) begin
         hw_select = i_int_page;
         hw_middle = page_select;
      end
      sw_page = i_dir_wdata[PAGE_W-1:0];
   end

   // Top of the stack: the live page select
   page_stack_cell #(
      .WIDTH(PAGE_W),
      .RESET_VALUE(PAGE_W'(PAGE_RESET))
   ) u_select (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_hw_load(stack_op != STACK_HOLD),
      .i_hw_value(hw_select),
      .i_sw_load(wr_select),
      .i_sw_value(sw_page),
      .o_value(page_select)
   );

   // Middle entry
   page_stack_cell #(
      .WIDTH(PAGE_W),
      .RESET_VALUE(PAGE_W'(PAGE_RESET))
   ) u_middle (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_hw_load(stack_op != STACK_HOLD),
      .i_hw_value(hw_middle),
      .i_sw_load(wr_middle),
      .i_sw_value(sw_page),
      .o_value(page_stack_middle)
   );

   // Bottom entry; a push overwrites any software value here
   page_stack_cell #(
      .WIDTH(PAGE_W),
      .RESET_VALUE(PAGE_W'(PAGE_RESET))
   ) u_bottom (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_hw_load(stack_op != STACK_HOLD),
      .i_hw_value((stack_op == STACK_PUSH) ? page_stack_middle
                  : PAGE_W'(EMPTY_PAGE)),
      .i_sw_load(wr_bottom),
      .i_sw_value(sw_page),
      .o_value(page_stack_bottom)
   );

   // ----------------------------------------------------------------
   // Data pointer and stack pointer
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] pointer_low_byte, pointer_high_byte, stack_top_pointer;
   logic [DATA_W-1:0] next_pointer_low_byte, next_pointer_high_byte;
   logic [DATA_W-1:0] next_stack_top_pointer;

   // The core's own push or pop wins over a direct write to the
   // stack pointer, matching the stack entries above
   always_comb begin
      next_pointer_low_byte = wr_ptr_lo ? i_dir_wdata : pointer_low_byte;
      next_pointer_high_byte = wr_ptr_hi ? i_dir_wdata : pointer_high_byte;
      next_stack_top_pointer = stack_top_pointer;
      if (i_stack_push) begin
         next_stack_top_pointer = stack_top_pointer + STACK_STEP;
      end else if (i_stack_pop) begin
         next_stack_top_pointer = stack_top_pointer - STACK_STEP;
      end else if (wr_top_ptr) begin
         next_stack_top_pointer = i_dir_wdata;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         pointer_low_byte <= POINTER_RESET;
         pointer_high_byte <= POINTER_RESET;
         stack_top_pointer <= STACK_TOP_RESET;
      end else begin
         pointer_low_byte <= next_pointer_low_byte;
         pointer_high_byte <= next_pointer_high_byte;
         stack_top_pointer <= next_stack_top_pointer;
      end
   end

   // ----------------------------------------------------------------
   // Read path and page qualifiers
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux, next_dir_rdata;
   logic rd_known, next_rd_hit;
   logic [PAGE_W-1:0] next_page_select;

   // Reads of core registers see the value before this cycle's update
   always_comb begin
      rd_known = 1'b1;
      unique case (i_dir_addr)
         ADDR_STACK_TOP_POINTER: rd_mux = stack_top_pointer;
         ADDR_POINTER_LOW_BYTE: rd_mux = pointer_low_byte;
         ADDR_POINTER_HIGH_BYTE: rd_mux = pointer_high_byte;
         ADDR_PAGE_CONTROL_REG: rd_mux = DATA_W'(auto_page_enable);
         ADDR_PAGE_SELECT: rd_mux = DATA_W'(page_select);
         ADDR_PAGE_STACK_MIDDLE: rd_mux = DATA_W'(page_stack_middle);
         ADDR_PAGE_STACK_BOTTOM: rd_mux = DATA_W'(page_stack_bottom);
         default: begin
            rd_mux = READ_ZERO;
            rd_known = 1'b0;
         end
      endcase
      next_rd_hit = i_dir_rd && in_special && rd_known;
      next_dir_rdata = next_rd_hit ? rd_mux : READ_ZERO;
   end

   // Qualifiers are taken from the next page so they line up with the
   // register they are compared against; the page lags no cycle
   always_comb begin
      next_page_select = page_select;
      if (stack_op == STACK_PUSH) begin
         next_page_select = i_int_page;
      end else if (stack_op == STACK_POP) begin
         next_page_select = page_stack_middle;
      end else if (wr_select) begin
         next_page_select = sw_page;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_dir_rdata <= READ_ZERO;
         o_dir_rd_hit <= 1'b0;
         o_page_low_active <= 1'b1;
         o_page_high_active <= 1'b0;
      end else begin
         o_dir_rdata <= next_dir_rdata;
         o_dir_rd_hit <= next_rd_hit;
         o_page_low_active <= (next_page_select == PAGE_W'(PAGE_LOW));
         o_page_high_active <= (next_page_select == PAGE_W'(PAGE_HIGH));
      end
   end

   assign o_page_select = page_select;
   assign o_indirect_pointer_16 = {pointer_high_byte, pointer_low_byte};
   assign o_stack_top_pointer = stack_top_pointer;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_push;
      auto_page_enable && i_int_enter;
   endsequence

   sequence s_pop;
      auto_page_enable && i_int_return && !i_int_enter;
   endsequence

   property p_entry_loads_page;
      s_push |=> (page_select == $past(i_int_page));
   endproperty
   a_entry_loads_page: assert property (p_entry_loads_page)
      else $error("entry did not load interrupt page");
   property p_push_shifts;
      s_push |=> (page_stack_middle == $past(page_select))
         && (page_stack_bottom == $past(page_stack_middle));
   endproperty
   a_push_shifts: assert property (p_push_shifts)
      else $error("push did not shift stack");
   property p_pop_shifts;
      s_pop |=> (page_select == $past(page_stack_middle))
         && (page_stack_middle == $past(page_stack_bottom))
         && (page_stack_bottom == PAGE_W'(EMPTY_PAGE));
   endproperty
   a_pop_shifts: assert property (p_pop_shifts)
      else $error("pop did not restore stack");
   property p_push_pop_round_trip;
      s_push ##1 (!i_int_enter && !i_int_return && !i_dir_wr)[*2]
         ##1 s_pop |=> (page_select == $past(page_select, 4));
   endproperty
   a_push_pop_round_trip: assert property (p_push_pop_round_trip)
      else $error("return did not restore prior page");
   property p_sw_middle_no_push;
      (wr_middle && !i_int_enter && !i_int_return) |=>
         $stable(page_select) && (page_stack_middle == $past(sw_page));
   endproperty
   a_sw_middle_no_push: assert property (p_sw_middle_no_push)
      else $error("stack write disturbed the stack");
   property p_quiet_stack;
      (!i_int_enter && !i_int_return && !i_dir_wr) |=>
         $stable(page_select) && $stable(page_stack_middle)
         && $stable(page_stack_bottom);
   endproperty
   a_quiet_stack: assert property (p_quiet_stack)
      else $error("stack moved without an event");
   property p_disabled_no_switch;
      (!auto_page_enable && !i_dir_wr) |=> $stable(page_select);
   endproperty
   a_disabled_no_switch: assert property (p_disabled_no_switch)
      else $error("page switched while disabled");
   property p_nested_overwrite;
      (wr_bottom ##1 s_push) |=>
         (page_stack_bottom == $past(page_stack_middle));
   endproperty
   a_nested_overwrite: assert property (p_nested_overwrite)
      else $error("push kept software bottom value");
   property p_top_ptr_increment;
      i_stack_push |=>
         (stack_top_pointer == $past(stack_top_pointer) + STACK_STEP);
   endproperty
   a_top_ptr_increment: assert property (p_top_ptr_increment)
      else $error("stack pointer not incremented");
   property p_pointer_read;
      (i_dir_rd && i_dir_addr == ADDR_POINTER_LOW_BYTE) |=>
         o_dir_rd_hit && (o_dir_rdata == $past(pointer_low_byte));
   endproperty
   a_pointer_read: assert property (p_pointer_read)
      else $error("pointer low read wrong");

endmodule // sfr_page_stack_and_pointers

`default_nettype wire

// file: bench/core_seq_model.sv
// Core sequencer and interrupt controller model driving the page block.
// Assumes the bench calls drive() just after each falling clock edge.
`default_nettype none

module core_seq_model (
   output logic [7:0] o_dir_addr,
   output logic o_dir_wr,
   output logic o_dir_rd,
   output logic [7:0] o_dir_wdata,
   output logic o_int_enter,
   output logic [7:0] o_int_page,
   output logic o_int_return,
   output logic o_stack_push,
   output logic o_stack_pop
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle from time zero
   initial begin
      o_dir_addr = 8'h00;
      o_dir_wdata = 8'h00;
      o_int_page = 8'h00;
      {o_dir_wr, o_dir_rd, o_int_enter, o_int_return} = 4'h0;
      {o_stack_push, o_stack_pop} = 2'h0;
   end

   // One cycle of requests; unqualified lines flip so stale bytes never pass
   task automatic drive(input logic [7:0] a, input logic wr, input logic rd,
      input logic [7:0] d, input logic ent, input logic [7:0] pg,
      input logic ret, input logic push, input logic pop);
      o_dir_addr = (wr || rd) ? a : ~o_dir_addr;
      o_dir_wr = wr;
      o_dir_rd = rd;
      o_dir_wdata = wr ? d : ~o_dir_wdata;
      o_int_enter = ent;
      o_int_page = ent ? pg : ~o_int_page;
      o_int_return = ret;
      o_stack_push = push;
      o_stack_pop = pop;
   endtask
endmodule // core_seq_model

`default_nettype wire

// file: bench/sfr_page_stack_and_pointers_tb.sv
// Self-checking bench: integer reference model compared every cycle.
// Assumes the core model drives all inputs at the falling clock edge.
`default_nettype none

module sfr_page_stack_and_pointers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import page_pkg::*;

   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [7:0] addr, wdata, ipage, rdata, psel, stkp;
   logic wr, rd, ent, ret, push, pop, hit, low_act, high_act;
   logic [15:0] ptr;
   int errors = 0;
   int compares = 0;
   int m_sel = 0, m_mid = 0, m_bot = 0, m_en = 1;
   int m_lo = 0, m_hi = 0, m_top = 7, m_hit = 0, m_rdata = 0;
   logic [31:0] rng = 32'h2974efeb;
   logic [7:0] addrs [8] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
      8'ha7, 8'h80};

   // 125 MHz core clock
   always #4 i_core_clk = ~i_core_clk;

   core_seq_model core (.o_dir_addr(addr), .o_dir_wr(wr), .o_dir_rd(rd),
      .o_dir_wdata(wdata), .o_int_enter(ent), .o_int_page(ipage),
      .o_int_return(ret), .o_stack_push(push), .o_stack_pop(pop));

   sfr_page_stack_and_pointers dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_dir_addr(addr), .i_dir_wr(wr), .i_dir_rd(rd), .i_dir_wdata(wdata),
      .i_int_enter(ent), .i_int_page(ipage), .i_int_return(ret),
      .i_stack_push(push), .i_stack_pop(pop), .o_dir_rdata(rdata),
      .o_dir_rd_hit(hit), .o_page_select(psel), .o_page_low_active(low_act),
      .o_page_high_active(high_act), .o_indirect_pointer_16(ptr),
      .o_stack_top_pointer(stkp));

   // ------------------------------------------------------------
   // Reference model and comparison
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Value a read returns, or -1 where the block gives no hit
   function automatic int reg_val(input logic [7:0] a);
      case (a)
         ADDR_STACK_TOP_POINTER: return m_top;
         ADDR_POINTER_LOW_BYTE: return m_lo;
         ADDR_POINTER_HIGH_BYTE: return m_hi;
         ADDR_PAGE_CONTROL_REG: return m_en;
         ADDR_PAGE_STACK_MIDDLE: return m_mid;
         ADDR_PAGE_STACK_BOTTOM: return m_bot;
         ADDR_PAGE_SELECT: return m_sel;
         default: return -1;
      endcase
   endfunction

   task automatic check(input logic [15:0] seen, input int exp,
      input string what);
      compares++;
      if (seen !== 16'(exp)) begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what,
            seen, 16'(exp));
      end
   endtask

   // One cycle: drive, let the edge land, update model, compare all outputs
   task automatic step(input logic [7:0] a, input logic w, input logic r,
      input logic [7:0] d, input logic en, input logic [7:0] pg,
      input logic rt, input logic pu, input logic po);
      int v;
      int hw;
      core.drive(a, w, r, d, en, pg, rt, pu, po);
      @(posedge i_core_clk);
      v = reg_val(a);
      hw = m_en && (en || rt);
      m_hit = r && v >= 0;
      m_rdata = m_hit ? v : 0;
      if (w) begin
         case (a)
            ADDR_STACK_TOP_POINTER: if (!pu && !po) m_top = d;
            ADDR_POINTER_LOW_BYTE: m_lo = d;
            ADDR_POINTER_HIGH_BYTE: m_hi = d;
            ADDR_PAGE_CONTROL_REG: m_en = d[0];
            ADDR_PAGE_STACK_MIDDLE: if (!hw) m_mid = d;
            ADDR_PAGE_STACK_BOTTOM: if (!hw) m_bot = d;
            ADDR_PAGE_SELECT: if (!hw) m_sel = d;
            default: ;
         endcase
      end
      if (hw && en) begin
         m_bot = m_mid;
         m_mid = m_sel;
         m_sel = pg;
      end else if (hw) begin
         m_sel = m_mid;
         m_mid = m_bot;
         m_bot = 0;
      end
      if (pu) m_top = (m_top + 1) & 255;
      else if (po) m_top = (m_top - 1) & 255;
      @(negedge i_core_clk);
      check(hit, m_hit, "read hit");
      check(rdata, m_rdata, "read data");
      check(psel, m_sel, "page select");
      check(low_act, m_sel == 0, "low page flag");
      check(high_act, m_sel == 15, "high page flag");
      check(ptr, m_hi * 256 + m_lo, "pointer");
      check(stkp, m_top, "stack pointer");
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      step(a, 1'b1, 1'b0, d, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      step(a, 1'b0, 1'b1, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog well beyond the few thousand cycles the tests take
   initial begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      finish_test();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(negedge i_core_clk);
      i_nrst = 1'b1;
      // Reset values, mapped and unmapped places
      for (int i = 0; i < 8; i++) rd_reg(addrs[i]);
      rd_reg(8'hff);
      $display("reset values done");
      // Nested entries then two returns; nested push drops soft bottom
      wr_reg(ADDR_PAGE_SELECT, PAGE_HIGH);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b1, PAGE_LOW, 1'b0, 1'b0, 1'b0);
      wr_reg(ADDR_PAGE_STACK_BOTTOM, 8'h33);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 8'h5a, 1'b0, 1'b0, 1'b0);
      rd_reg(ADDR_PAGE_STACK_BOTTOM);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0);
      rd_reg(ADDR_PAGE_STACK_MIDDLE);
      rd_reg(ADDR_PAGE_STACK_BOTTOM);
      $display("nesting done");
      // Soft write of middle redirects the return page
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b1, PAGE_HIGH, 1'b0, 1'b0, 1'b0);
      wr_reg(ADDR_PAGE_STACK_MIDDLE, 8'h05);
      wr_reg(ADDR_PAGE_SELECT, 8'h44);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0);
      $display("stack rewrite done");
      // Auto paging off: entry and return leave the stack alone
      wr_reg(ADDR_PAGE_CONTROL_REG, 8'hfe);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b1, PAGE_HIGH, 1'b0, 1'b0, 1'b0);
      step(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0);
      rd_reg(ADDR_PAGE_CONTROL_REG);
      wr_reg(ADDR_PAGE_CONTROL_REG, 8'h01);
      $display("auto paging off done");
      // Random mix of accesses, interrupts and core pushes
      for (int i = 0; i < 3000; i++) begin
         rng = xs(rng);
         step(rng[3] ? rng[15:8] : addrs[rng[2:0]], rng[17:16] == 2'h1,
            rng[17:16] == 2'h2, rng[31:24], rng[20:18] == 3'h0,
            rng[5] ? PAGE_HIGH : rng[27:20], rng[23:21] == 3'h0,
            rng[4] && rng[5], rng[6] && rng[7] && !(rng[4] && rng[5]));
      end
      $display("random mix done");
      finish_test();
   end
endmodule // sfr_page_stack_and_pointers_tb

`default_nettype wire
